/* File: rtl/ijp_pin_ctl.sv */
// How it works
// - test port enabled when pin config, pld input or software bit is true
// - with test port off, the four basic pins follow general port logic
// - enabled pins stay inputs until serial command; then data output drives
// - dedicated configuration keeps the pins in test-port use permanently
// - shared configuration: one pld input from port b, c or d re-enables
// - software enable bit in control register is one enabling source
// - any reset clears the control register and its enable bit
// - status and error extension pins enabled only together by serial command
// - error pin driven low when erase or program ends in error
// - status pin reads inactive high while flash is in read mode
// - status pin low while program or erase cycle runs
// - extension pins default open drain, may switch to push pull
// - delivered programmable-logic bits read as erased ones
// - delivered configuration bits are all zero
// - blank device has basic test pins enabled without prior configuration
`timescale 1ns/1ps
module ijp_pin_ctl
	import ijp_pkg::*;
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic [PIN_W-1:0]  pin_i,
	output logic      [PIN_W-1:0]  pin_o,
	output logic      [PIN_W-1:0]  pin_oe,
	input  wire logic [PIN_W-1:0]  gpio_out,
	input  wire logic [PIN_W-1:0]  gpio_oe,
	input  wire logic [PLD_W-1:0]  pld_in,
	input  wire logic              flash_busy,
	input  wire logic              flash_error,
	output logic                   irq
);

	ijp_state_s r_reg;
	ijp_state_s r_next;

	logic             jtag_on;
	logic             pld_on;
	logic             tck_rise;
	logic             tck_fall;
	logic             addr_ok;
	logic             busy_fall;
	logic             err_event;
	logic             chan_event;
	logic             stat_val;
	logic             err_val;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [1:0]       sel;

	function automatic logic [31:0] read_mux(input logic [7:0] a, input ijp_state_s s,
	                                         input logic on);
		logic [31:0] v;
		v = RDATA_ZERO;
		case (a)
			OFS_CTRL:     v[CTRL_SW_EN] = s.sw_en;
			OFS_CONFIG:   v[CFG_W-1:0] = s.cfg;
			OFS_STATUS: begin
				v[STS_JTAG_ON] = on;
				v[STS_CHAN_ON] = s.chan_on;
				v[STS_EXT_ON]  = s.ext_on;
				v[STS_BUSY]    = s.busy_d;
				v[STS_ERROR]   = s.err_lat;
			end
			OFS_IRQ_STAT: v[IRQ_W-1:0] = s.irq_st;
			OFS_IRQ_EN:   v[IRQ_W-1:0] = s.irq_en;
			OFS_PLD_IMG:  v = s.pld_img;
			default:      v = RDATA_ZERO;
		endcase
		return v;
	endfunction : read_mux

	// drives an extension pin in open drain or push pull fashion
	function automatic logic [1:0] ext_drive(input logic val, input logic pp);
		logic [1:0] d;
		d = {1'b0, 1'b0};
		if (pp) begin
			d = {val, 1'b1};
		end else begin
			d = {1'b0, ~val};
		end
		return d;
	endfunction : ext_drive

	always_comb begin
		sel       = r_reg.cfg[CFG_SEL_LO +: 2];
		pld_on    = (sel < 2'(PLD_W)) ? r_reg.pld_s[sel] : 1'b0;
		jtag_on   = ~r_reg.cfg[CFG_SHARED]
		            | (r_reg.cfg[CFG_SHARED] & pld_on)
		            | r_reg.sw_en;
		tck_rise  = r_reg.pin_s[PIN_TCK] & ~r_reg.tck_d;
		tck_fall  = ~r_reg.pin_s[PIN_TCK] & r_reg.tck_d;
		busy_fall = r_reg.busy_d & ~flash_busy;
		err_event = flash_error & r_reg.ext_on;
		addr_ok   = (haddr == OFS_CTRL) | (haddr == OFS_CONFIG) | (haddr == OFS_STATUS)
		            | (haddr == OFS_IRQ_STAT) | (haddr == OFS_IRQ_CLR)
		            | (haddr == OFS_IRQ_EN) | (haddr == OFS_PLD_IMG);

		r_next         = r_reg;
		chan_event     = 1'b0;
		r_next.pin_m   = pin_i;
		r_next.pin_s   = r_reg.pin_m;
		r_next.pld_m   = pld_in;
		r_next.pld_s   = r_reg.pld_m;
		r_next.tck_d   = r_reg.pin_s[PIN_TCK];
		r_next.busy_d  = flash_busy;

		// serial channel, clocked by sampled test clock edges
		if (!jtag_on) begin
			r_next.chan_on = 1'b0;
			r_next.ext_on  = 1'b0;
			r_next.shift   = '0;
		end else if (tck_rise) begin
			if (r_reg.pin_s[PIN_TMS]) begin
				// tms high closes a command; the shifted byte is decoded
				case (r_reg.shift)
					CMD_CHAN_ON: begin
						r_next.chan_on = 1'b1;
						chan_event     = ~r_reg.chan_on;
					end
					CMD_EXT_ON: begin
						r_next.chan_on = 1'b1;
						r_next.ext_on  = 1'b1;
						chan_event     = ~r_reg.chan_on;
					end
					CMD_OFF: begin
						r_next.chan_on = 1'b0;
						r_next.ext_on  = 1'b0;
					end
					default: begin
						r_next.chan_on = r_reg.chan_on;
					end
				endcase
				r_next.shift = '0;
			end else begin
				r_next.shift = {r_reg.pin_s[PIN_TDI], r_reg.shift[CMD_W-1:1]};
			end
		end else if (tck_fall) begin
			r_next.tdo_bit = r_reg.shift[0];
		end

		// error flag holds until the next program or erase starts
		if (flash_error) begin
			r_next.err_lat = 1'b1;
		end else if (flash_busy & ~r_reg.busy_d) begin
			r_next.err_lat = 1'b0;
		end

		// bus write lands in the data phase
		if (r_reg.wr_pend) begin
			case (r_reg.wr_addr)
				OFS_CTRL:    r_next.sw_en = hwdata[CTRL_SW_EN];
				OFS_CONFIG:  r_next.cfg = hwdata[CFG_W-1:0];
				OFS_IRQ_EN:  r_next.irq_en = hwdata[IRQ_W-1:0];
				OFS_PLD_IMG: r_next.pld_img = hwdata;
				default:     r_next.sw_en = r_reg.sw_en;
			endcase
		end
		r_next.wr_pend = 1'b0;
		r_next.rdata   = RDATA_ZERO;
		if (hsel & htrans[1] & hready) begin
			r_next.wr_pend = hwrite & addr_ok;
			r_next.wr_addr = haddr;
			if (!hwrite) begin
				r_next.rdata = read_mux(haddr, r_reg, jtag_on);
			end
		end

		// sticky events; a set in the clearing cycle survives
		irq_set = '0;
		irq_set[IRQ_ERROR] = err_event;
		irq_set[IRQ_DONE]  = busy_fall;
		irq_set[IRQ_CHAN]  = chan_event;
		irq_clr = (r_reg.wr_pend && r_reg.wr_addr == OFS_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;
		r_next.irq_st = (r_reg.irq_st & ~irq_clr) | irq_set;
		r_next.irq    = |(r_next.irq_st & r_reg.irq_en);

		// pin drive: general port logic unless the test port owns the pins
		r_next.pin_o  = gpio_out;
		r_next.pin_oe = gpio_oe;
		if (jtag_on) begin
			r_next.pin_o[PIN_TMS]  = 1'b0;
			r_next.pin_oe[PIN_TMS] = 1'b0;
			r_next.pin_o[PIN_TCK]  = 1'b0;
			r_next.pin_oe[PIN_TCK] = 1'b0;
			r_next.pin_o[PIN_TDI]  = 1'b0;
			r_next.pin_oe[PIN_TDI] = 1'b0;
			r_next.pin_o[PIN_TDO]  = r_reg.tdo_bit;
			r_next.pin_oe[PIN_TDO] = r_reg.chan_on;
		end
		// extension pins follow the flash state only while enabled as a pair
		stat_val = ~flash_busy;
		err_val  = ~r_next.err_lat;
		if (r_reg.ext_on) begin
			{r_next.pin_o[PIN_STAT], r_next.pin_oe[PIN_STAT]} =
				ext_drive(stat_val, r_reg.cfg[CFG_PUSH_PULL]);
			{r_next.pin_o[PIN_ERR], r_next.pin_oe[PIN_ERR]} =
				ext_drive(err_val, r_reg.cfg[CFG_PUSH_PULL]);
		end
	end

	// reset puts back the delivery state: config zero, logic image erased
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg         <= '0;
			r_reg.sw_en   <= 1'b0;
			r_reg.cfg     <= CFG_RESET;
			r_reg.pld_img <= PLD_ERASED;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hrdata    = r_reg.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign pin_o     = r_reg.pin_o;
	assign pin_oe    = r_reg.pin_oe;
	assign irq       = r_reg.irq;

endmodule : ijp_pin_ctl

/* File: rtl/ijp_pkg.sv */
package ijp_pkg;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_CONFIG   = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;
	localparam logic [7:0]  OFS_IRQ_STAT = 8'h0C;
	localparam logic [7:0]  OFS_IRQ_CLR  = 8'h10;
	localparam logic [7:0]  OFS_IRQ_EN   = 8'h14;
	localparam logic [7:0]  OFS_PLD_IMG  = 8'h18;

	// field positions
	localparam int CTRL_SW_EN    = 0;
	localparam int CFG_SHARED    = 0;
	localparam int CFG_PUSH_PULL = 1;
	localparam int CFG_SEL_LO    = 2;
	localparam int CFG_W         = 4;
	localparam int STS_JTAG_ON   = 0;
	localparam int STS_CHAN_ON   = 1;
	localparam int STS_EXT_ON    = 2;
	localparam int STS_BUSY      = 3;
	localparam int STS_ERROR     = 4;
	localparam int IRQ_ERROR     = 0;
	localparam int IRQ_DONE      = 1;
	localparam int IRQ_CHAN      = 2;
	localparam int IRQ_W         = 3;

	// pin slots of the shared port
	localparam int PIN_TMS  = 0;
	localparam int PIN_TCK  = 1;
	localparam int PIN_STAT = 2;
	localparam int PIN_ERR  = 3;
	localparam int PIN_TDI  = 4;
	localparam int PIN_TDO  = 5;
	localparam int PIN_W    = 6;
	localparam int PLD_W    = 3;

	// serial commands, values arbitrary
	localparam int          CMD_W       = 8;
	localparam logic [7:0]  CMD_CHAN_ON = 8'hA5;
	localparam logic [7:0]  CMD_EXT_ON  = 8'hA7;
	localparam logic [7:0]  CMD_OFF     = 8'h5A;

	// reset values
	localparam logic [CFG_W-1:0] CFG_RESET  = 4'h0;
	localparam logic [31:0]      PLD_ERASED = 32'hFFFFFFFF;
	localparam logic [31:0]      RDATA_ZERO = 32'h00000000;

	typedef struct packed {
		logic [PIN_W-1:0] pin_m;
		logic [PIN_W-1:0] pin_s;
		logic [PLD_W-1:0] pld_m;
		logic [PLD_W-1:0] pld_s;
		logic             tck_d;
		logic [CMD_W-1:0] shift;
		logic             tdo_bit;
		logic             chan_on;
		logic             ext_on;
		logic             busy_d;
		logic             err_lat;
		logic             sw_en;
		logic [CFG_W-1:0] cfg;
		logic [31:0]      pld_img;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic             irq;
		logic             wr_pend;
		logic [7:0]       wr_addr;
		logic [31:0]      rdata;
		logic [PIN_W-1:0] pin_o;
		logic [PIN_W-1:0] pin_oe;
	} ijp_state_s;
endpackage : ijp_pkg

/* File: tb/ijp_jtag_host.sv */
`timescale 1ns/1ps
module ijp_jtag_host #(
	parameter int HALF = 200
) (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic cable_enable_output_n
);
	initial begin
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
		cable_enable_output_n = 1'b1;
	end
	// wired to the reserved pld input by the board
	task automatic cable(input logic on);
		cable_enable_output_n = ~on;
	endtask : cable
	// eight data clocks lsb first, then one mode-high clock; clock idles low
	task automatic send(input logic [7:0] c);
		#13;
		for (int i = 0; i < 9; i++) begin
			tms = (i == 8);
			tdi = (i < 8) ? c[i] : 1'b0;
			#(HALF) tck = 1'b1;
			#(HALF) tck = 1'b0;
		end
		tms = 1'b0;
		tdi = ~tdi;
	endtask : send
endmodule : ijp_jtag_host

/* File: tb/ijp_pin_ctl_properties.sv */
`timescale 1ns/1ps
module ijp_pin_ctl_chk
	import ijp_pkg::*;
(
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic [7:0]       haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic             hready,
	input wire logic [31:0]      hwdata,
	input wire logic [31:0]      hrdata,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic [PIN_W-1:0] pin_oe,
	input wire logic [PIN_W-1:0] gpio_oe,
	input wire logic             irq
);
	logic ph_reg;
	logic wen_reg;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_reg <= 1'b0;
			wen_reg <= 1'b0;
		end else begin
			ph_reg <= hsel & htrans[1] & hready;
			wen_reg <= hsel & htrans[1] & hready & hwrite & (haddr == OFS_IRQ_EN);
		end
	end
	a_ready_high: assert property (hreadyout) else $error("ready dropped");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_rdata_idle: assert property (!ph_reg |-> hrdata == RDATA_ZERO) else $error("stray data");
	a_tms_input: assert property (pin_oe[PIN_TMS] |-> $past(gpio_oe[PIN_TMS]))
		else $error("mode pin driven");
	a_tck_input: assert property (pin_oe[PIN_TCK] |-> $past(gpio_oe[PIN_TCK]))
		else $error("clock pin driven");
	a_tdi_input: assert property (pin_oe[PIN_TDI] |-> $past(gpio_oe[PIN_TDI]))
		else $error("data in pin driven");
	a_reset_quiet: assert property (@(posedge hclk) disable iff (1'b0)
		!hresetn |-> !irq && pin_oe == '0) else $error("outputs active in reset");
	a_irq_drop: assert property (wen_reg && hwdata[IRQ_W-1:0] == '0 |-> ##[1:2] !irq)
		else $error("masked irq stays high");
	c_irq: cover property ($rose(irq));
	c_tdo: cover property ($rose(pin_oe[PIN_TDO]));
	c_mask: cover property (wen_reg);
endmodule : ijp_pin_ctl_chk
bind ijp_pin_ctl ijp_pin_ctl_chk u_ijp_pin_ctl_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .pin_oe, .gpio_oe, .irq);

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import ijp_pkg::*;
	logic        hclk = 1'b0, hresetn = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, r;
	logic        hreadyout, hresp, irq, tck, tms, tdi, cen_n, busy = 1'b0, ferr = 1'b0;
	logic [5:0]  pin_i, pin_o, pin_oe, gpio_oe = 6'h3F, gpio_out = 6'h2A;
	logic [2:0]  pld_in = 3'h0;
	int          bad_count = 0, compares = 0;
	always #25 hclk = ~hclk;
	always @(posedge hclk) pld_in <= {2'h0, ~cen_n};
	// undriven test inputs follow the host; the other undriven pins float to their pull-ups
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & {1'b1, tdi, 2'h3, tck, tms});
	ijp_pin_ctl u_ijp_pin_ctl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pin_i, .pin_o, .pin_oe,
		.gpio_out, .gpio_oe, .pld_in, .flash_busy(busy), .flash_error(ferr), .irq);
	ijp_jtag_host u_ijp_jtag_host (.tck, .tms, .tdi, .cable_enable_output_n(cen_n));
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic hrdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		if (hreadyout !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t bus hang", $time);
			give_verdict();
		end
	endtask : hrdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		hrdy();
		r = hrdata;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rd
	// serial decode needs sync and edge detect, a handful of cycles
	task automatic cmd(input logic [7:0] c);
		u_ijp_jtag_host.send(c);
		repeat (8) @(posedge hclk);
	endtask : cmd
	initial begin
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_CONFIG, 32'h0);
		rd(OFS_PLD_IMG, PLD_ERASED);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STATUS, 32'h1);
		rd(8'h1C, 32'h0);
		chk({pin_oe, pin_o & 6'h0C}, 12'h308);
		$display("test reset done");
		bus(1'b1, OFS_IRQ_EN, 32'h7);
		cmd(CMD_CHAN_ON);
		chk(pin_oe[PIN_TDO], 1'b1);
		rd(OFS_STATUS, 32'h3);
		rd(OFS_IRQ_STAT, 32'h4);
		chk(irq, 1'b1);
		bus(1'b1, OFS_IRQ_CLR, 32'h4);
		rd(OFS_IRQ_STAT, 32'h0);
		chk(irq, 1'b0);
		$display("test channel done");
		cmd(CMD_EXT_ON);
		rd(OFS_STATUS, 32'h7);
		chk(pin_i[PIN_STAT], 1'b1);
		busy <= 1'b1;
		repeat (2) @(posedge hclk);
		ferr <= 1'b1;
		repeat (2) @(posedge hclk);
		ferr <= 1'b0;
		chk({pin_i[3:2], pin_o[3:2]}, 4'h0);
		rd(OFS_STATUS, 32'h1F);
		busy <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(pin_i[PIN_STAT], 1'b1);
		rd(OFS_IRQ_STAT, 32'h3);
		bus(1'b1, OFS_CONFIG, 32'h2);
		repeat (2) @(posedge hclk);
		chk({pin_oe[3:2], pin_o[3:2]}, 4'hD);
		bus(1'b1, OFS_IRQ_EN, 32'h0);
		rd(OFS_IRQ_STAT, 32'h3);
		chk(irq, 1'b0);
		busy <= 1'b1;
		@(posedge hclk);
		busy <= 1'b0;
		cmd(CMD_OFF);
		rd(OFS_STATUS, 32'h1);
		$display("test extension done");
		bus(1'b1, OFS_CONFIG, 32'h1);
		repeat (2) @(posedge hclk);
		chk({pin_oe, pin_o}, {6'h3F, 6'h2A});
		rd(OFS_STATUS, 32'h0);
		u_ijp_jtag_host.cable(1'b1);
		repeat (5) @(posedge hclk);
		rd(OFS_STATUS, 32'h1);
		chk(pin_oe & 6'h33, 32'h0);
		u_ijp_jtag_host.cable(1'b0);
		bus(1'b1, OFS_CTRL, 32'h1);
		repeat (5) @(posedge hclk);
		rd(OFS_STATUS, 32'h1);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(OFS_CTRL, 32'h0);
		$display("test sharing done");
		give_verdict();
	end
endmodule : tb
